// ### core/card_clock_irq_regs.sv
/*
  Register bank for slot-three card clock and answer counters, the device
  interrupt summary and the device settings. Registers are reached over I2C.
  Assumes the flag inputs are level signals from logic on ref_clk and that
  the module input clock and general pins arrive from pins.
*/
`timescale 1ns/1ps
module card_clock_irq_regs
  import card_regs_pkg::*;
#(
  parameter logic [7:0] VERSION = 8'h5A  // Arbitrary value.
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             irq_n,
  input  wire logic        module_input_clock,
  output logic             slot3_card_clock,
  output logic             slot3_internal_clock_active,
  output logic [9:0]       slot3_early_count,
  output logic [15:0]      slot3_timeout_count,
  input  wire logic [4:0]  user_card_flags,
  input  wire logic [3:0]  slot1_flags,
  input  wire logic [3:0]  slot2_flags,
  input  wire logic [3:0]  slot3_flags,
  input  wire logic        over_temp_fault,
  input  wire logic        supervisor_fault,
  input  wire logic        sync_activation_done,
  input  wire logic [3:0]  general_pin_level,
  output logic             deactivate_all,
  output logic             boost_enable,
  output logic [3:0]       general_pin_dir
);
  import card_regs_pkg::*;

  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [2:0]  clock_mode;
  logic [2:0]  divider;
  logic [7:0]  early_high;
  logic [1:0]  early_low;
  logic [7:0]  timeout_high;
  logic [7:0]  timeout_low;
  logic [7:0]  status;
  logic [7:0]  next_status;
  logic [7:0]  set_vec;
  logic [16:0] flag_prev;
  logic [1:0]  fault_prev;
  logic        sync_prev;
  logic [2:0]  clkin_s;
  logic        clkin_rise;
  logic [3:0]  edge_cnt;
  logic [3:0]  ratio;
  logic        divided;
  logic [6:0]  osc_cnt;
  logic        osc_level;
  logic        next_card_clock;
  logic [3:0]  pin_s1;
  logic [3:0]  pin_s2;
  logic [3:0]  pin_s3;

  i2c_byte_port #(.DEV_ADDR(I2C_DEVICE_ADDR)) u_port (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // Clock select register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clock_mode <= RST_CLOCK_MODE;
      divider    <= RST_DIVIDER; // R4
    end else if (reg_wr && reg_addr == OFS_CLOCK_SELECT) begin
      clock_mode <= reg_wdata[BIT_INTERNAL_OSC -: 3];
      divider    <= reg_wdata[BIT_DIV_LSB +: 3];
    end
  end

  // Answer window counters.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      early_high   <= RST_EARLY_HIGH; // R5
      early_low    <= RST_EARLY_LOW; // R6
      timeout_high <= RST_TIMEOUT_HIGH; // R7
      timeout_low  <= RST_TIMEOUT_LOW; // R7
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_EARLY_HIGH:   early_high <= reg_wdata; // R5
        OFS_EARLY_LOW:    early_low <= reg_wdata[BIT_EARLY_LOW +: 2]; // R6
        OFS_TIMEOUT_HIGH: timeout_high <= reg_wdata; // R7
        OFS_TIMEOUT_LOW:  timeout_low <= reg_wdata; // R7
        default:          early_low <= early_low;
      endcase
    end
  end

  assign slot3_early_count   = {early_high, early_low}; // R5 R6
  assign slot3_timeout_count = {timeout_high, timeout_low}; // R7

  // Device settings register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      boost_enable    <= RST_BOOST; // R16
      general_pin_dir <= RST_PIN_DIR; // R17
    end else if (reg_wr && reg_addr == OFS_DEVICE_SETTING) begin
      boost_enable    <= reg_wdata[BIT_BOOST]; // R16
      general_pin_dir <= reg_wdata[BIT_PIN_DIR_LSB +: 4]; // R17
    end
  end

  // Read mux; undefined bits and offsets read zero.
  always_comb begin
    case (reg_addr)
      OFS_CLOCK_SELECT:   reg_rdata = {clock_mode, divider, 2'b00}; // R20
      OFS_EARLY_HIGH:     reg_rdata = early_high;
      OFS_EARLY_LOW:      reg_rdata = {early_low, 6'h00}; // R20
      OFS_TIMEOUT_HIGH:   reg_rdata = timeout_high;
      OFS_TIMEOUT_LOW:    reg_rdata = timeout_low;
      OFS_VERSION:        reg_rdata = VERSION;
      OFS_IRQ_SUMMARY:    reg_rdata = status;
      OFS_DEVICE_SETTING: reg_rdata = {boost_enable, 1'b0, general_pin_dir, 2'b00}; // R20
      default:            reg_rdata = 8'h00; // R20
    endcase
  end

  // Input clock and general pins come from pins and pass two flip-flops.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clkin_s <= 3'h0;
      pin_s1  <= 4'h0;
      pin_s2  <= 4'h0;
      pin_s3  <= 4'h0;
    end else begin
      clkin_s <= {clkin_s[1:0], module_input_clock};
      pin_s1  <= general_pin_level;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
    end
  end

  assign clkin_rise = clkin_s[1] & ~clkin_s[2];
  assign ratio      = divide_ratio(divider); // R4

  // Divider counts input clock rising edges.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      edge_cnt <= 4'h0;
    end else if (clkin_rise) begin
      edge_cnt <= (edge_cnt + 4'h1 >= ratio) ? 4'h0 : edge_cnt + 4'h1; // R4
    end
  end

  assign divided = (ratio == 4'h1) ? clkin_s[1] : (edge_cnt < (ratio >> 1)); // R4

  // Internal oscillator from a divider of the system clock.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_cnt   <= 7'h00;
      osc_level <= 1'b0;
    end else if (osc_cnt == 7'(OSC_HALF_CYC - 1)) begin
      osc_cnt   <= 7'h00;
      osc_level <= ~osc_level; // R1
    end else begin
      osc_cnt <= osc_cnt + 7'h01;
    end
  end

  always_comb begin
    if (clock_mode[2]) begin
      next_card_clock = osc_level; // R1
    end else if (clock_mode[1]) begin
      next_card_clock = 1'b0; // R2
    end else if (clock_mode[0]) begin
      next_card_clock = 1'b1; // R3
    end else begin
      next_card_clock = divided; // R3 R4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slot3_card_clock <= 1'b0;
    end else begin
      slot3_card_clock <= next_card_clock;
    end
  end

  assign slot3_internal_clock_active = clock_mode[2];

  // Event edge detection.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_prev  <= 17'h00000;
      fault_prev <= 2'h0;
      sync_prev  <= 1'b0;
    end else begin
      flag_prev  <= {user_card_flags, slot1_flags, slot2_flags, slot3_flags};
      fault_prev <= {over_temp_fault, supervisor_fault};
      sync_prev  <= sync_activation_done;
    end
  end

  always_comb begin
    set_vec = 8'h00;
    set_vec[BIT_USER_CARD]  = |(user_card_flags & ~flag_prev[16:12]); // R8
    set_vec[BIT_SLOT1]      = |(slot1_flags & ~flag_prev[11:8]); // R9
    set_vec[BIT_SLOT2]      = |(slot2_flags & ~flag_prev[7:4]); // R9
    set_vec[BIT_SLOT3]      = |(slot3_flags & ~flag_prev[3:0]); // R9 R18
    set_vec[BIT_OVER_TEMP]  = over_temp_fault & ~fault_prev[1]; // R12
    set_vec[BIT_SUPERVISOR] = supervisor_fault & ~fault_prev[0]; // R13
    set_vec[BIT_SYNC_DONE]  = sync_activation_done & ~sync_prev; // R14
    set_vec[BIT_PIN_CHANGE] = |((pin_s2 ^ pin_s3) & general_pin_dir); // R15
    // A set arriving with the clearing read wins.
    if (reg_rd && reg_addr == OFS_IRQ_SUMMARY) begin
      next_status = set_vec; // R11
    end else begin
      next_status = status | set_vec;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status         <= 8'h00;
      deactivate_all <= 1'b0;
      irq_n          <= 1'b1;
    end else begin
      status         <= next_status;
      deactivate_all <= set_vec[BIT_OVER_TEMP] | set_vec[BIT_SUPERVISOR]; // R12 R13
      irq_n          <= ~|next_status; // R10
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Select bits take priority in the order internal, low, high.
  sequence mode_held(sel);
    sel ##1 sel;
  endsequence

  sequence dir_steady;
    $stable(general_pin_dir) ##1 $stable(general_pin_dir);
  endsequence

  internal_osc_a: assert property (mode_held(clock_mode[2]) // R1
    |-> slot3_card_clock == $past(osc_level))
    else $error("card clock not following internal oscillator");
  force_low_a: assert property (mode_held(clock_mode[2:1] == 2'h1) |-> !slot3_card_clock) // R2
    else $error("card clock not held low");
  force_high_a: assert property (mode_held(clock_mode == 3'h1) |-> slot3_card_clock) // R3
    else $error("card clock not held high");
  reset_values_a: assert property ($fell(reset) |-> divider == 3'h3 // R4
    && slot3_early_count == 10'h2A8 && slot3_timeout_count == 16'hA474 && boost_enable)
    else $error("register reset value wrong");
  slot3_summary_a: assert property ($rose(slot3_flags[0]) |=> status[4] && !irq_n) // R18
    else $error("slot three event not flagged");
  user_summary_a: assert property ($rose(user_card_flags[4]) |=> status[7] ##1 status[7]) // R8
    else $error("user card event not held");
  irq_pin_a: assert property (status != 8'h00 |-> !irq_n) // R10
    else $error("interrupt pin not low with status set");
  read_clear_a: assert property ((reg_rd && reg_addr == OFS_IRQ_SUMMARY && set_vec == 8'h00) // R11
    |=> status == 8'h00 && irq_n)
    else $error("status not cleared by read");
  fault_deact_a: assert property ($rose(over_temp_fault) |=> deactivate_all && status[3]) // R12
    else $error("over-temperature not handled");
  supervisor_a: assert property ($rose(supervisor_fault) |=> deactivate_all && status[2]) // R13
    else $error("supervisor fault not handled");
  pin_change_a: assert property ((|(general_pin_dir // R15
    & (general_pin_level ^ $past(general_pin_level))) && $stable(general_pin_dir))
    ##1 dir_steady |=> status[0])
    else $error("input pin change not flagged");
  boost_write_a: assert property ((reg_wr && reg_addr == OFS_DEVICE_SETTING) // R16 R17
    |=> boost_enable == $past(reg_wdata[7]) && general_pin_dir == $past(reg_wdata[5:2]))
    else $error("settings write not applied");
  sync_done_a: assert property ($rose(sync_activation_done) |=> status[1] && !irq_n) // R14
    else $error("sync activation completion not flagged");
  slot1_summary_a: assert property ($rose(slot1_flags[3]) |=> status[6] && !irq_n) // R9
    else $error("first slot event not flagged");
  slot2_summary_a: assert property ($rose(slot2_flags[3]) |=> status[5] && !irq_n) // R9
    else $error("second slot event not flagged");
  clock_write_a: assert property ((reg_wr && reg_addr == OFS_CLOCK_SELECT) // R4
    |=> clock_mode == $past(reg_wdata[7:5]) && divider == $past(reg_wdata[4:2]))
    else $error("clock select write not applied");
  early_write_a: assert property ((reg_wr && reg_addr == OFS_EARLY_LOW) // R6
    |=> early_low == $past(reg_wdata[7:6]))
    else $error("early count low bits not written");
  timeout_write_a: assert property ((reg_wr && reg_addr == OFS_TIMEOUT_LOW) // R7
    |=> slot3_timeout_count[7:0] == $past(reg_wdata))
    else $error("timeout count low byte not written");
  deact_cause_a: assert property (deactivate_all |-> status[3] || status[2]) // R12 R13
    else $error("deactivation without a fault flag");
  osc_steady_a: assert property (osc_cnt != 7'h00 |-> osc_level == $past(osc_level)) // R1
    else $error("internal oscillator toggled mid half period");
endmodule : card_clock_irq_regs

// ### core/card_regs_pkg.sv
/*
  Constants for the slot-three clock, answer counters, interrupt summary
  and device settings register bank of the multi-slot card interface.
  Assumes one 100 MHz clock and single-byte register access over I2C.
*/
// How it works
// (R1) Internal select gives about 1.2 MHz clock.
// (R2) Force-low holds card clock at zero.
// (R3) Force-high holds clock high, else divider.
// (R4) Divider codes: 1,2,4,5, then 8; reset 5.
// (R5) Early count upper byte resets to AA.
// (R6) Early count lower bits 7:6, reset zero.
// (R7) Timeout count two bytes, reset A4 74.
// (R8) Status bit 7 flags any user-card event.
// (R9) Status bits 6..4 flag module slot events.
// (R10) Interrupt pin low while any status set.
// (R11) Status bits read-only, cleared by read.
// (R12) Over-temperature deactivates cards, sets bit 3.
// (R13) Supervisor fault deactivates cards, sets bit 2.
// (R14) Sync activation done sets bit 1.
// (R15) Input general pin change sets bit 0.
// (R16) Settings bit 7 enables boost, reset one.
// (R17) Settings bits 5:2 set pin directions.
// (R18) Early answer flag raises slot summary bit.
// (R19) Host uses single-byte I2C transfers.
// (R20) Undefined bits read zero, ignore writes.
package card_regs_pkg;
  localparam logic [7:0] OFS_CLOCK_SELECT   = 8'h32;
  localparam logic [7:0] OFS_EARLY_HIGH     = 8'h33;
  localparam logic [7:0] OFS_EARLY_LOW      = 8'h34;
  localparam logic [7:0] OFS_TIMEOUT_HIGH   = 8'h35;
  localparam logic [7:0] OFS_TIMEOUT_LOW    = 8'h36;
  localparam logic [7:0] OFS_VERSION        = 8'h40;
  localparam logic [7:0] OFS_IRQ_SUMMARY    = 8'h41;
  localparam logic [7:0] OFS_DEVICE_SETTING = 8'h42;

  localparam int BIT_INTERNAL_OSC = 7;
  localparam int BIT_FORCE_LOW    = 6;
  localparam int BIT_FORCE_HIGH   = 5;
  localparam int BIT_DIV_LSB      = 2;
  localparam int BIT_EARLY_LOW    = 6;
  localparam int BIT_USER_CARD    = 7;
  localparam int BIT_SLOT1        = 6;
  localparam int BIT_SLOT2        = 5;
  localparam int BIT_SLOT3        = 4;
  localparam int BIT_OVER_TEMP    = 3;
  localparam int BIT_SUPERVISOR   = 2;
  localparam int BIT_SYNC_DONE    = 1;
  localparam int BIT_PIN_CHANGE   = 0;
  localparam int BIT_BOOST        = 7;
  localparam int BIT_PIN_DIR_LSB  = 2;

  localparam logic [2:0] RST_CLOCK_MODE   = 3'h0;
  localparam logic [2:0] RST_DIVIDER      = 3'h3;
  localparam logic [7:0] RST_EARLY_HIGH   = 8'hAA;
  localparam logic [1:0] RST_EARLY_LOW    = 2'h0;
  localparam logic [7:0] RST_TIMEOUT_HIGH = 8'hA4;
  localparam logic [7:0] RST_TIMEOUT_LOW  = 8'h74;
  localparam logic       RST_BOOST        = 1'b1;
  localparam logic [3:0] RST_PIN_DIR      = 4'h0;

  localparam int CLOCK_KHZ    = 100000;
  localparam int OSC_KHZ      = 1200;
  localparam int OSC_HALF_CYC = CLOCK_KHZ / (2 * OSC_KHZ);
  localparam logic [6:0] I2C_DEVICE_ADDR = 7'h36;

  // Divide ratio for each divider code.
  function automatic logic [3:0] divide_ratio(input logic [2:0] code);
    case (code)
      3'h0:    divide_ratio = 4'h1;
      3'h1:    divide_ratio = 4'h2;
      3'h2:    divide_ratio = 4'h4;
      3'h3:    divide_ratio = 4'h5;
      default: divide_ratio = 4'h8;
    endcase
  endfunction : divide_ratio
endpackage : card_regs_pkg

// ### core/i2c_byte_port.sv
/*
  I2C target that turns single-byte transfers into register strobes.
  Assumes scl and sda arrive from pins; sda is open drain.
*/
`timescale 1ns/1ps
module i2c_byte_port
  import card_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = card_regs_pkg::I2C_DEVICE_ADDR
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_ADDR = 7'h02, ST_ADDR_ACK = 7'h04, ST_WRITE = 7'h08,
    ST_WRITE_ACK = 7'h10, ST_READ = 7'h20, ST_READ_ACK = 7'h40
  } i2c_state_t;

  i2c_state_t state;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic       have_ptr;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end

  assign scl_rise   = scl_s[1] & ~scl_s[2];
  assign scl_fall   = ~scl_s[1] & scl_s[2];
  assign start_seen = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_seen  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  assign sda_out    = 1'b0;
  assign reg_wdata  = shift;
  assign reg_wr     = scl_fall && state == ST_WRITE && bit_cnt == 4'h8 && have_ptr;
  assign reg_rd     = scl_fall && ((state == ST_ADDR_ACK && shift[0])
                                   || state == ST_READ_ACK);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state    <= ST_IDLE;
      shift    <= 8'h00;
      bit_cnt  <= 4'h0;
      have_ptr <= 1'b0;
      reg_addr <= 8'h00;
      sda_oe   <= 1'b0;
    end else if (start_seen) begin
      state   <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop_seen) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (state == ST_ADDR || state == ST_WRITE) begin
        shift   <= {shift[6:0], sda_s[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (state == ST_READ_ACK && sda_s[1]) begin
        state <= ST_IDLE;
      end
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (bit_cnt == 4'h8) begin
            state  <= (shift[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            sda_oe <= (shift[7:1] == DEV_ADDR);
          end
        end
        ST_ADDR_ACK, ST_READ_ACK: begin
          if (state == ST_READ_ACK || shift[0]) begin
            shift    <= reg_rdata;
            sda_oe   <= ~reg_rdata[7];
            bit_cnt  <= 4'h1;
            reg_addr <= reg_addr + 8'h01;
            state    <= ST_READ;
          end else begin
            sda_oe   <= 1'b0;
            bit_cnt  <= 4'h0;
            have_ptr <= 1'b0;
            state    <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (bit_cnt == 4'h8) begin
            sda_oe <= 1'b1;
            state  <= ST_WRITE_ACK;
            if (!have_ptr) begin
              reg_addr <= shift;
              have_ptr <= 1'b1;
            end else begin
              // The write strobe of this cycle still sees the old pointer.
              reg_addr <= reg_addr + 8'h01;
            end
          end
        end
        ST_WRITE_ACK: begin
          sda_oe  <= 1'b0;
          bit_cnt <= 4'h0;
          state   <= ST_WRITE;
        end
        ST_READ: begin
          if (bit_cnt == 4'h8) begin
            sda_oe <= 1'b0;
            state  <= ST_READ_ACK;
          end else begin
            shift   <= {shift[6:0], 1'b0};
            sda_oe  <= ~shift[6];
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ack_on_match_a: assert property (@(posedge ref_clk) disable iff (reset)
    (scl_fall && state == ST_ADDR && bit_cnt == 4'h8 && shift[7:1] == DEV_ADDR)
    |=> sda_oe && state == ST_ADDR_ACK)
    else $error("address match not acknowledged");
endmodule : i2c_byte_port

// ### verif/i2c_host.sv
/*
  Host model that makes single-byte register transfers over I2C.
  Assumes the bench resolves the open-drain SDA line with a pull-up.
*/
`timescale 1ns/1ps
module i2c_host
  import card_regs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : hold

  // SCL phases stay at 8 clocks, well above the target's minimum of 5.
  task automatic put_bit(input logic b);
    sda_pull = ~b;
    hold(4);
    scl = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    b = sda_line;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask : get_bit

  task automatic send(input logic [7:0] v, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    ok = ok & ~a;
  endtask : send

  task automatic start();
    sda_pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask : start

  task automatic stop();
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b0;
    hold(8);
  endtask : stop

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    send({I2C_DEVICE_ADDR, 1'b0}, ok);
    send(a, ok);
    send(d, ok);
    stop();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic b;
    ok = 1'b1;
    start();
    send({I2C_DEVICE_ADDR, 1'b0}, ok);
    send(a, ok);
    start();
    send({I2C_DEVICE_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(1'b1);
    stop();
  endtask : read_reg
endmodule : i2c_host

// ### verif/tb.sv
/*
  Self-checking bench for the card clock, counter and interrupt registers.
  Assumes the i2c_host model as bus master and one 100 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  import card_regs_pkg::*;
  localparam logic [7:0] VER = 8'hC3;  // Arbitrary value.
  localparam int LIMIT = 80000;
  localparam int RATIO [8] = '{1, 2, 4, 5, 8, 8, 8, 8};
  localparam logic [7:0] ROFS [8] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h40, 8'h41, 8'h42};
  localparam logic [7:0] RVAL [8] = '{8'h0C, 8'hAA, 8'h00, 8'hA4, 8'h74, VER, 8'h00, 8'h80};
  logic        ref_clk, reset, scl, sda_pull, sda_line, sda_out, sda_oe, irq_n;
  logic        in_clk, card_clk, osc_on, deact, boost;
  logic [9:0]  early;
  logic [15:0] tmo;
  logic [19:0] ev;
  logic [3:0]  pins, dir;
  int          mismatches, total_checks, cycles;

  assign sda_line = ~sda_pull & ~(sda_oe & ~sda_out);

  i2c_host u_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
  card_clock_irq_regs #(.VERSION(VER)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq_n(irq_n), .module_input_clock(in_clk), .slot3_card_clock(card_clk),
    .slot3_internal_clock_active(osc_on), .slot3_early_count(early),
    .slot3_timeout_count(tmo), .user_card_flags(ev[19:15]), .slot1_flags(ev[14:11]),
    .slot2_flags(ev[10:7]), .slot3_flags(ev[6:3]), .over_temp_fault(ev[2]),
    .supervisor_fault(ev[1]), .sync_activation_done(ev[0]), .general_pin_level(pins),
    .deactivate_all(deact), .boost_enable(boost), .general_pin_dir(dir));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    in_clk = 1'b0;
    forever begin
      repeat (5) @(negedge ref_clk);
      in_clk = ~in_clk;
    end
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles == LIMIT) begin
        mismatches++;
        results();
      end
    end
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.write_reg(a, d, ok);
    check(ok, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.read_reg(a, d, ok);
    check(ok, 1'b1);
    check(d, exp);
  endtask : rd

  // Cycles between two rising card clock edges, zero if fewer than two come.
  task automatic period(output logic [15:0] p);
    int   n, e, t0;
    logic prev;
    n = 0;
    e = 0;
    t0 = 0;
    p = 16'h0;
    prev = card_clk;
    while (n < 800 && e < 2) begin
      @(negedge ref_clk);
      n++;
      if (card_clk === 1'b1 && prev === 1'b0) begin
        e++;
        p = 16'(n - t0);
        t0 = n;
      end
      prev = card_clk;
    end
    if (e < 2) p = 16'h0;
  endtask : period

  task automatic t_reset_values();
    check(early, 10'h2A8);
    check(tmo, 16'hA474);
    check({boost, dir, irq_n, osc_on}, 7'h42);
    for (int i = 0; i < 8; i++) rd(ROFS[i], RVAL[i]);
  endtask : t_reset_values

  task automatic t_access();
    wr(OFS_EARLY_LOW, 8'hFF);
    rd(OFS_EARLY_LOW, 8'hC0);
    wr(OFS_EARLY_HIGH, 8'h5B);
    wr(OFS_TIMEOUT_HIGH, 8'h12);
    wr(OFS_TIMEOUT_LOW, 8'h9E);
    check(early, 10'h16F);
    check(tmo, 16'h129E);
    rd(OFS_TIMEOUT_LOW, 8'h9E);
    wr(OFS_DEVICE_SETTING, 8'h7F);
    rd(OFS_DEVICE_SETTING, 8'h3C);
    check({boost, dir}, 5'h0F);
    wr(OFS_VERSION, 8'hFF);
    wr(OFS_IRQ_SUMMARY, 8'hFF);
    rd(OFS_VERSION, VER);
    rd(OFS_IRQ_SUMMARY, 8'h00);
    check(irq_n, 1'b1);
    rd(8'h50, 8'h00);
    wr(OFS_DEVICE_SETTING, 8'h80);
  endtask : t_access

  // Each flag source in turn: summary bit, pin, deactivation and clear on read.
  task automatic t_events();
    int   s;
    logic dv;
    for (int i = 0; i < 20; i++) begin
      s = i > 14 ? 7 : i > 10 ? 6 : i > 6 ? 5 : i > 2 ? 4 : i + 1;
      ev[i] = 1'b1;
      @(negedge ref_clk);
      dv = deact;
      ev[i] = 1'b0;
      @(negedge ref_clk);
      check(irq_n, 1'b0);
      check(dv | deact, s == 3 || s == 2);
      rd(OFS_IRQ_SUMMARY, 8'h1 << s);
      check(irq_n, 1'b1);
    end
  endtask : t_events

  task automatic t_pins();
    wr(OFS_DEVICE_SETTING, 8'h84);
    pins[0] = ~pins[0];
    repeat (8) @(negedge ref_clk);
    check(irq_n, 1'b0);
    rd(OFS_IRQ_SUMMARY, 8'h01);
    pins[1] = ~pins[1];
    repeat (8) @(negedge ref_clk);
    check(irq_n, 1'b1);
    wr(OFS_DEVICE_SETTING, 8'h80);
  endtask : t_pins

  task automatic t_clock();
    logic [15:0] p;
    wr(OFS_CLOCK_SELECT, 8'hFC);
    period(p);
    period(p);
    check(osc_on, 1'b1);
    check(p >= 76 && p <= 92, 1'b1);
    rd(OFS_CLOCK_SELECT, 8'hFC);
    wr(OFS_CLOCK_SELECT, 8'h7C);
    period(p);
    check(p, 16'h0);
    check(card_clk, 1'b0);
    wr(OFS_CLOCK_SELECT, 8'h3C);
    period(p);
    check(p, 16'h0);
    check(card_clk, 1'b1);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CLOCK_SELECT, 8'(c << 2));
      period(p);
      period(p);
      check(p, 16'(10 * RATIO[c]));
      check(osc_on, 1'b0);
    end
  endtask : t_clock

  initial begin
    reset = 1'b1;
    ev = '0;
    pins = 4'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    t_reset_values();
    t_access();
    t_events();
    t_pins();
    t_clock();
    results();
  end
endmodule : tb
